// >>> design/bscan_defs.svh
// bscan_defs.svh: offsets, cell positions, codes and reset values
// assumes inclusion by bare name from the package and the design files
`ifndef BSCAN_DEFS_SVH
`define BSCAN_DEFS_SVH

`define IR_W 3
`define ID_W 32
`define BSR_W 196
`define OUT_N 31
`define IN_N 47

`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE 3'h2
`define IR_CLAMP 3'h3
`define IR_HIGHZ 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE 3'h1

// active-low enable cells of the boundary register, then the last output pin cell
`define CELL_FRAMER_EN 18
`define CELL_TXSOF_EN 20
`define CELL_IRQ_EN 26
`define CELL_DATA_EN 61
`define CELL_FACT_EN 81
`define CELL_LAST_PIN 82

// positions in the output pin vector
`define PIN_TXSOF 10
`define PIN_IRQ 11

// register indices; byte address is four times the index
`define IDX_MFG_ONE 12'h040
`define IDX_MFG_TWO 12'h042
`define IDX_MFG_THREE 12'h044
`define IDX_MFG_FOUR 12'h046
`define IDX_STATUS 12'h048
`define IDX_CTRL 12'h04A

`define MFG_ONE_RST 16'h0000
`define MFG_TWO_RST 16'h0000
`define MFG_THREE_RST 16'h0000
`define MFG_FOUR_RST 16'h0000
`define CTRL_RST 1'b1

// identification value: arbitrary
`define ID_CODE_DEF 32'h0A5A_5001

`endif

// >>> design/bscan_pkg.sv
// bscan_pkg: types shared by the boundary-scan test register files
// assumes bscan_defs.svh is on the include path
`include "bscan_defs.svh"

package bscan_pkg;

  // gray codes along the scan paths
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SDR = 4'h3, CDR = 4'h2,
    SHD = 4'h6, X1D = 4'h7, PDR = 4'h5, X2D = 4'h4,
    UDR = 4'hC, SIR = 4'hD, CIR = 4'hF, SHI = 4'hE,
    X1I = 4'hA, PIR = 4'hB, X2I = 4'h9, UIR = 4'h8
  } tap_state_t;

  typedef struct packed {
    logic clock;
    logic mode_select;
    logic serial_in;
  } scan_pins_t;

  typedef struct packed {
    logic [`OUT_N-1:0] value;
    logic [`OUT_N-1:0] enable;
  } pin_drive_t;

  typedef struct packed {
    logic hit;
    logic write;
    logic [11:0] index;
  } ahb_req_t;

endpackage : bscan_pkg

// >>> design/scan_shift_latch.sv
// scan_shift_latch: shift stage with a latched parallel output
// assumes strobes are single hclk pulses from the owning scan logic
`timescale 1ns/100ps
`default_nettype none

module scan_shift_latch #(
  parameter int W = 32,
  parameter logic [W-1:0] PRESET = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic capture,
  input wire logic [W-1:0] capture_value,
  input wire logic shift,
  input wire logic serial_in,
  input wire logic update,
  input wire logic preset,
  output logic [W-1:0] shift_q,
  output logic [W-1:0] latch_q
);

  typedef struct packed {
    logic [W-1:0] sh;
    logic [W-1:0] lat;
  } stage_t;

  stage_t st;
  stage_t next_st;

  always_comb begin
    next_st = st;
    if (capture) begin
      next_st.sh = capture_value;
    end else if (shift) begin
      next_st.sh = {serial_in, st.sh[W-1:1]};
    end
    if (preset) begin
      next_st.lat = PRESET;
    end else if (update) begin
      next_st.lat = st.sh;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= {PRESET, PRESET};
    end else begin
      st <= next_st;
    end
  end

  assign shift_q = st.sh;
  assign latch_q = st.lat;

endmodule : scan_shift_latch

`default_nettype wire

// >>> design/boundary_scan_test_registers.sv
// boundary_scan_test_registers: bypass, identification and boundary
// registers with the scan port, pad muxing and manufacturing registers
// assumes scan pins and pad inputs are asynchronous to hclk and that
// scan_clock runs well below hclk; single AHB-Lite slave, word access
// How it works
// - under clamp, outputs come from the boundary latch and hold still
// - under clamp, the bypass stage sits between serial in and out
// - bypass is one stage, used by bypass, clamp and high-z
// - identification register has a 32-bit shift and 32-bit latch
// - identification register selected by its code and in scan reset
// - boundary register is 196 cells with shift and latched stages
// - bypass, boundary and identification registers are all present
// - cells 18, 61 and 81 are active-low enables of their pin groups
// - cell 20 enables tx frame start, cell 26 the interrupt pin
// - cells 0 to 7 factory pins, 8 master clock, 9 tx clock
// - cells 10 to 15 rx framer outputs, 16 counter update, 17 tx data
// - address bit 7 at cell 64 down to bit 0 at 71, latch at 72
// - cells 73 to 75 float, test, reset; 76 to 80 and 82 line factory pins
// - reset restores the manufacturing registers to working values
// - instruction register is 3 bits, shifting in shift-instruction
// - captured identification value always has bit 0 set
`timescale 1ns/100ps
`default_nettype none
`include "bscan_defs.svh"

module boundary_scan_test_registers #(
  // arbitrary value
  parameter logic [31:0] ID_CODE = `ID_CODE_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scan_clock,
  input wire logic scan_mode_select,
  input wire logic scan_serial_in,
  output logic scan_serial_out,
  output logic scan_serial_out_enable,
  input wire bscan_pkg::pin_drive_t core_drive,
  input wire logic global_float_low,
  input wire logic [`IN_N-1:0] pin_in,
  output logic [`OUT_N-1:0] pin_out,
  output logic [`OUT_N-1:0] pin_oe,
  output logic [`ID_W-1:0] id_parallel,
  output logic [63:0] mfg_check_regs
);

  // boundary cell of each output pin, in pin vector order
  localparam int unsigned OUT_CELL [`OUT_N] = '{
    3, 4, 5,
    10, 11, 12, 13, 14, 15,
    19, 21, 27,
    31, 33, 35, 37, 39, 41, 43, 45,
    47, 49, 51, 53, 55, 57, 59, 62,
    79, 80, 82
  };

  // boundary cell of each input pin, in pin vector order
  localparam int unsigned IN_CELL [`IN_N] = '{
    0, 1, 2, 6, 7, 8, 9,
    16, 17,
    22, 23, 24, 25, 28, 29, 30,
    32, 34, 36, 38, 40, 42, 44, 46,
    48, 50, 52, 54, 56, 58, 60, 63,
    64, 65, 66, 67, 68, 69, 70, 71, 72,
    73, 74, 75, 76, 77, 78
  };

  typedef struct packed {
    bscan_pkg::scan_pins_t pins1;
    bscan_pkg::scan_pins_t pins2;
    logic clk_prev;
    logic [`IN_N-1:0] in1;
    logic [`IN_N-1:0] in2;
    logic float1;
    logic float2;
    bscan_pkg::tap_state_t tap;
    logic bypass;
    logic tdo;
    logic tdo_en;
    bscan_pkg::pin_drive_t drive;
    bscan_pkg::ahb_req_t req;
    logic ready;
    logic resp;
    logic [31:0] rdata;
    logic [3:0][15:0] mfg;
    logic scan_on;
  } state_t;

  state_t st;
  state_t next_st;

  logic rise;
  logic fall;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;
  logic sel_id;
  logic sel_bs;
  logic sel_byp;
  logic is_clamp;
  logic take;
  logic [`IR_W-1:0] instr;
  logic [`IR_W-1:0] ir_sh;
  logic [`ID_W-1:0] id_sh;
  logic [`BSR_W-1:0] bs_sh;
  logic [`BSR_W-1:0] bs_lat;
  logic [`BSR_W-1:0] bs_cap;

  // enable cell that governs a given output cell
  function automatic int unsigned grp_cell(input int unsigned c);
    if (c <= 5 || c >= 79) begin
      grp_cell = `CELL_FACT_EN;
    end else if (c <= 19) begin
      grp_cell = `CELL_FRAMER_EN;
    end else if (c == 21) begin
      grp_cell = `CELL_TXSOF_EN;
    end else if (c == 27) begin
      grp_cell = `CELL_IRQ_EN;
    end else begin
      grp_cell = `CELL_DATA_EN;
    end
  endfunction : grp_cell

  function automatic bscan_pkg::tap_state_t tap_step(
    input bscan_pkg::tap_state_t s, input logic m);
    unique case (s)
      bscan_pkg::TLR: tap_step = m ? bscan_pkg::TLR : bscan_pkg::RTI;
      bscan_pkg::RTI: tap_step = m ? bscan_pkg::SDR : bscan_pkg::RTI;
      bscan_pkg::SDR: tap_step = m ? bscan_pkg::SIR : bscan_pkg::CDR;
      bscan_pkg::CDR: tap_step = m ? bscan_pkg::X1D : bscan_pkg::SHD;
      bscan_pkg::SHD: tap_step = m ? bscan_pkg::X1D : bscan_pkg::SHD;
      bscan_pkg::X1D: tap_step = m ? bscan_pkg::UDR : bscan_pkg::PDR;
      bscan_pkg::PDR: tap_step = m ? bscan_pkg::X2D : bscan_pkg::PDR;
      bscan_pkg::X2D: tap_step = m ? bscan_pkg::UDR : bscan_pkg::SHD;
      bscan_pkg::UDR: tap_step = m ? bscan_pkg::SDR : bscan_pkg::RTI;
      bscan_pkg::SIR: tap_step = m ? bscan_pkg::TLR : bscan_pkg::CIR;
      bscan_pkg::CIR: tap_step = m ? bscan_pkg::X1I : bscan_pkg::SHI;
      bscan_pkg::SHI: tap_step = m ? bscan_pkg::X1I : bscan_pkg::SHI;
      bscan_pkg::X1I: tap_step = m ? bscan_pkg::UIR : bscan_pkg::PIR;
      bscan_pkg::PIR: tap_step = m ? bscan_pkg::X2I : bscan_pkg::PIR;
      bscan_pkg::X2I: tap_step = m ? bscan_pkg::UIR : bscan_pkg::SHI;
      bscan_pkg::UIR: tap_step = m ? bscan_pkg::SDR : bscan_pkg::RTI;
    endcase
  endfunction : tap_step

  // scan clock edges seen through the synchroniser
  assign rise = st.pins2.clock & ~st.clk_prev;
  assign fall = ~st.pins2.clock & st.clk_prev;
  assign cap_dr = rise && st.tap == bscan_pkg::CDR;
  assign sh_dr = rise && st.tap == bscan_pkg::SHD;
  assign upd_dr = fall && st.tap == bscan_pkg::UDR;
  assign cap_ir = rise && st.tap == bscan_pkg::CIR;
  assign sh_ir = rise && st.tap == bscan_pkg::SHI;
  assign upd_ir = fall && st.tap == bscan_pkg::UIR;

  assign sel_id = instr == `IR_IDCODE || st.tap == bscan_pkg::TLR;
  assign sel_bs = instr == `IR_EXTEST || instr == `IR_SAMPLE;
  // clamp, high-z, bypass and unused codes take the bypass stage
  assign sel_byp = !sel_id && !sel_bs;
  assign is_clamp = instr == `IR_CLAMP;
  assign take = hsel && hready && htrans[1];

  // capture: pads and driven outputs; spare cells keep their bits
  always_comb begin
    bs_cap = bs_sh;
    for (int i = 0; i < `OUT_N; i++) begin
      bs_cap[grp_cell(OUT_CELL[i])] = ~st.drive.enable[i];
      bs_cap[OUT_CELL[i]] = st.drive.value[i];
    end
    for (int i = 0; i < `IN_N; i++) begin
      bs_cap[IN_CELL[i]] = st.in2[i];
    end
  end

  scan_shift_latch #(
    .W(`IR_W),
    .PRESET(`IR_IDCODE)
  ) u_instr (
    .clk(hclk),
    .rst_n(hresetn),
    .capture(cap_ir),
    .capture_value(`IR_CAPTURE),
    .shift(sh_ir),
    .serial_in(st.pins2.serial_in),
    .update(upd_ir),
    .preset(st.tap == bscan_pkg::TLR),
    .shift_q(ir_sh),
    .latch_q(instr)
  );

  scan_shift_latch #(
    .W(`ID_W),
    .PRESET('0)
  ) u_ident (
    .clk(hclk),
    .rst_n(hresetn),
    .capture(cap_dr && sel_id),
    .capture_value({ID_CODE[31:1], 1'b1}),
    .shift(sh_dr && sel_id),
    .serial_in(st.pins2.serial_in),
    .update(upd_dr && sel_id),
    .preset(1'b0),
    .shift_q(id_sh),
    .latch_q(id_parallel)
  );

  scan_shift_latch #(
    .W(`BSR_W),
    .PRESET('0)
  ) u_boundary (
    .clk(hclk),
    .rst_n(hresetn),
    .capture(cap_dr && sel_bs),
    .capture_value(bs_cap),
    .shift(sh_dr && sel_bs),
    .serial_in(st.pins2.serial_in),
    .update(upd_dr && sel_bs),
    .preset(1'b0),
    .shift_q(bs_sh),
    .latch_q(bs_lat)
  );

  always_comb begin
    logic [31:0] rd;
    rd = 32'h0000_0000;
    next_st = st;
    next_st.pins1 = '{clock: scan_clock, mode_select: scan_mode_select,
                      serial_in: scan_serial_in};
    next_st.pins2 = st.pins1;
    next_st.clk_prev = st.pins2.clock;
    next_st.in1 = pin_in;
    next_st.in2 = st.in1;
    next_st.float1 = global_float_low;
    next_st.float2 = st.float1;

    if (!st.scan_on) begin
      next_st.tap = bscan_pkg::TLR;
    end else if (rise) begin
      next_st.tap = tap_step(st.tap, st.pins2.mode_select);
    end

    if (cap_dr && sel_byp) begin
      next_st.bypass = 1'b0;
    end else if (sh_dr && sel_byp) begin
      next_st.bypass = st.pins2.serial_in;
    end

    // serial out changes on the falling scan edge
    if (fall) begin
      next_st.tdo_en = st.tap == bscan_pkg::SHD ||
                       st.tap == bscan_pkg::SHI;
      if (st.tap == bscan_pkg::SHI) begin
        next_st.tdo = ir_sh[0];
      end else if (sel_id) begin
        next_st.tdo = id_sh[0];
      end else if (sel_bs) begin
        next_st.tdo = bs_sh[0];
      end else begin
        next_st.tdo = st.bypass;
      end
    end

    for (int i = 0; i < `OUT_N; i++) begin
      if (instr == `IR_EXTEST || is_clamp) begin
        next_st.drive.value[i] = bs_lat[OUT_CELL[i]];
        next_st.drive.enable[i] = ~bs_lat[grp_cell(OUT_CELL[i])];
      end else begin
        next_st.drive.value[i] = core_drive.value[i];
        next_st.drive.enable[i] = core_drive.enable[i] & st.float2 &
                                  (instr != `IR_HIGHZ);
      end
    end

    // register bus: zero wait, read data set up in the address phase
    next_st.req = '{hit: take, write: hwrite, index: haddr[13:2]};
    case (haddr[13:2])
      `IDX_MFG_ONE: rd = {16'h0000, st.mfg[0]};
      `IDX_MFG_TWO: rd = {16'h0000, st.mfg[1]};
      `IDX_MFG_THREE: rd = {16'h0000, st.mfg[2]};
      `IDX_MFG_FOUR: rd = {16'h0000, st.mfg[3]};
      `IDX_STATUS: rd = {23'h00_0000, sel_bs, st.tap, 1'b0, instr};
      `IDX_CTRL: rd = {31'h0000_0000, st.scan_on};
      default: rd = 32'h0000_0000;
    endcase
    next_st.rdata = (take && !hwrite) ? rd : 32'h0000_0000;

    if (st.req.hit && st.req.write) begin
      case (st.req.index)
        `IDX_MFG_ONE: next_st.mfg[0] = hwdata[15:0];
        `IDX_MFG_TWO: next_st.mfg[1] = hwdata[15:0];
        `IDX_MFG_THREE: next_st.mfg[2] = hwdata[15:0];
        `IDX_MFG_FOUR: next_st.mfg[3] = hwdata[15:0];
        `IDX_CTRL: next_st.scan_on = hwdata[0];
        default: next_st.scan_on = st.scan_on;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.ready <= 1'b1;
      st.scan_on <= `CTRL_RST;
      st.mfg <= {`MFG_FOUR_RST, `MFG_THREE_RST,
                 `MFG_TWO_RST, `MFG_ONE_RST};
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.ready;
  assign hresp = st.resp;
  assign hrdata = st.rdata;
  assign scan_serial_out = st.tdo;
  assign scan_serial_out_enable = st.tdo_en;
  assign pin_out = st.drive.value;
  assign pin_oe = st.drive.enable;
  assign mfg_check_regs = st.mfg;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_clamp_steady;
    is_clamp ##1 is_clamp;
  endsequence

  property p_clamp_hold;
    s_clamp_steady |=> $stable(pin_out) && $stable(pin_oe);
  endproperty
  a_clamp_hold: assert property (p_clamp_hold)
    else $error("outputs moved under clamp");

  property p_clamp_bypass;
    fall && is_clamp && st.tap == bscan_pkg::SHD
      |=> scan_serial_out == $past(st.bypass);
  endproperty
  a_clamp_bypass: assert property (p_clamp_bypass)
    else $error("clamp serial out not from bypass");

  property p_bypass_one;
    sh_dr && sel_byp |=> st.bypass == $past(st.pins2.serial_in);
  endproperty
  a_bypass_one: assert property (p_bypass_one)
    else $error("bypass stage did not take serial in");

  property p_id_update;
    upd_dr && sel_id |=> id_parallel == $past(id_sh);
  endproperty
  a_id_update: assert property (p_id_update)
    else $error("identification latch missed update");

  property p_reset_ident;
    st.tap == bscan_pkg::TLR |=> instr == `IR_IDCODE && sel_id;
  endproperty
  a_reset_ident: assert property (p_reset_ident)
    else $error("scan reset did not select identification");

  property p_bs_shift;
    sh_dr && sel_bs |=> bs_sh[`BSR_W-2:0] == $past(bs_sh[`BSR_W-1:1])
      && bs_sh[`BSR_W-1] == $past(st.pins2.serial_in);
  endproperty
  a_bs_shift: assert property (p_bs_shift)
    else $error("boundary shift wrong");

  property p_irq_enable;
    instr == `IR_EXTEST ##1 instr == `IR_EXTEST
      |-> pin_oe[`PIN_IRQ] == ~$past(bs_lat[`CELL_IRQ_EN]);
  endproperty
  a_irq_enable: assert property (p_irq_enable)
    else $error("interrupt pin enable not from its cell");

  property p_data_enable;
    is_clamp ##1 is_clamp
      |-> pin_oe[12] == ~$past(bs_lat[`CELL_DATA_EN]);
  endproperty
  a_data_enable: assert property (p_data_enable)
    else $error("data bus enable not from its cell");

  property p_ir_capture;
    cap_ir |=> ir_sh == `IR_CAPTURE ##1 ir_sh == `IR_CAPTURE;
  endproperty
  a_ir_capture: assert property (p_ir_capture)
    else $error("instruction capture value wrong");

  property p_id_lsb;
    cap_dr && sel_id |=> id_sh[0] == 1'b1 && id_sh[31:1] == ID_CODE[31:1];
  endproperty
  a_id_lsb: assert property (p_id_lsb)
    else $error("identification capture wrong");

  property p_spare_cells;
    cap_dr && sel_bs
      |=> bs_sh[`BSR_W-1:83] == $past(bs_sh[`BSR_W-1:83]);
  endproperty
  a_spare_cells: assert property (p_spare_cells)
    else $error("spare cells changed on capture");

endmodule : boundary_scan_test_registers

`default_nettype wire

// >>> dv/scan_master.sv
// scan_master: behavioural test controller on the far side of the scan port
// assumes the block finds scan clock edges with its own faster clock
`timescale 1ns/100ps
`default_nettype none

module scan_master (
  output logic scan_clock,
  output logic scan_mode_select,
  output logic scan_serial_in,
  input wire logic scan_serial_out,
  input wire logic scan_serial_out_enable
);
  // released serial out reads as its pull-up level
  wire logic line_seen = scan_serial_out_enable ? scan_serial_out : 1'b1;

  // clock rests low between frames; pulled-up lines rest high
  initial begin
    scan_clock = 1'b0;
    scan_mode_select = 1'b1;
    scan_serial_in = 1'b1;
  end

  // serial out sampled just before the rising edge
  task automatic step(input logic ms, input logic si, output logic so);
    scan_mode_select = ms;
    scan_serial_in = si;
    #62.5;
    so = line_seen;
    scan_clock = 1'b1;
    #62.5;
    scan_clock = 1'b0;
  endtask : step

  task automatic reset_walk();
    logic so;
    for (int i = 0; i < 5; i++) step(1'b1, 1'b1, so);
  endtask : reset_walk

  // one scan of n bits, lsb first, ending in run-test-idle
  task automatic scan(input logic ir, input int n, input logic [255:0] din,
                      output logic [255:0] dout);
    logic so;
    dout = '0;
    step(1'b0, 1'b1, so);
    step(1'b1, 1'b1, so);
    if (ir) step(1'b1, 1'b1, so);
    step(1'b0, 1'b1, so);
    step(1'b0, 1'b1, so);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], so);
      dout[i] = so;
    end
    step(1'b1, 1'b1, so);
    step(1'b0, 1'b1, so);
    scan_serial_in = 1'b1;
  endtask : scan
endmodule : scan_master

`default_nettype wire

// >>> dv/boundary_scan_test_registers_test.sv
// boundary_scan_test_registers_test: register bus and scan port tests
// assumes scan_master drives the scan pins; one AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "bscan_defs.svh"

module boundary_scan_test_registers_test;
  // arbitrary value, even so the forced low bit shows
  localparam logic [31:0] ID_VAL = 32'h1357_9BDE;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, idw;
  logic scan_clock, scan_mode_select, scan_serial_in, scan_serial_out;
  logic so_en;
  logic [15:0] mfg_rst [4] = '{`MFG_ONE_RST, `MFG_TWO_RST, `MFG_THREE_RST,
                               `MFG_FOUR_RST};
  bscan_pkg::pin_drive_t core_drive;
  logic global_float_low;
  logic [`IN_N-1:0] pin_in, got_in;
  logic [`OUT_N-1:0] pin_out, pin_oe, ev, ee;
  logic [`ID_W-1:0] id_parallel;
  logic [63:0] mfg_check_regs;
  logic [255:0] so, pat;
  logic [2:0] codes [5] = '{3'h7, 3'h3, 3'h4, 3'h5, 3'h6};
  logic [11:0] mfg [4] = '{`IDX_MFG_ONE, `IDX_MFG_TWO, `IDX_MFG_THREE,
                          `IDX_MFG_FOUR};
  int err_total = 0;
  int checks = 0;

  always #5 hclk = ~hclk;

  boundary_scan_test_registers #(
    .ID_CODE(ID_VAL)
  ) boundary_scan_test_registers_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .scan_clock(scan_clock),
    .scan_mode_select(scan_mode_select), .scan_serial_in(scan_serial_in),
    .scan_serial_out(scan_serial_out), .scan_serial_out_enable(so_en),
    .core_drive(core_drive), .global_float_low(global_float_low),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .id_parallel(id_parallel), .mfg_check_regs(mfg_check_regs)
  );

  scan_master scan_master_i (
    .scan_clock(scan_clock), .scan_mode_select(scan_mode_select),
    .scan_serial_in(scan_serial_in), .scan_serial_out(scan_serial_out),
    .scan_serial_out_enable(so_en)
  );

  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic cmp(input string what, input logic [255:0] exp,
                     input logic [255:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // ready and read data both taken at the rising edge
  task automatic wait_ready(output logic [31:0] d);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      d = hrdata;
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      close_out();
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [11:0] idx,
                     input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(d);
    cmp("hresp", 256'h0, hresp);
  endtask : ahb

  task automatic load_ir(input logic [2:0] code);
    scan_master_i.scan(1'b1, 3, {253'h0, code}, so);
    cmp("ir capture", `IR_CAPTURE, so[2:0]);
    repeat (6) @(posedge hclk);
    ahb(1'b0, `IDX_STATUS, 32'h0, rd);
    cmp("current instruction", code, rd[2:0]);
  endtask : load_ir

  task automatic id_chk(input logic [63:0] din);
    scan_master_i.reset_walk();
    scan_master_i.scan(1'b0, 64, {192'h0, din}, so);
    cmp("id code", ID_VAL | 32'h1, so[31:0]);
    cmp("id length", din[31:0], so[63:32]);
    cmp("out enable idle", 256'h0, so_en);
    repeat (6) @(posedge hclk);
    cmp("id latch", din[63:32], id_parallel);
  endtask : id_chk

  function automatic void pins_of(input logic [255:0] p,
                                  output logic [30:0] v,
                                  output logic [30:0] e);
    int c, g;
    for (int j = 0; j < 31; j++) begin
      if (j < 3) c = 3 + j;
      else if (j < 9) c = 7 + j;
      else if (j < 12) c = (j == 9) ? 19 : (j == 10) ? 21 : 27;
      else if (j < 27) c = 31 + 2 * (j - 12);
      else if (j == 27) c = 62;
      else c = (j == 30) ? 82 : 51 + j;
      g = (j < 3 || j > 27) ? 81 : (j < 10) ? 18 : (j == 10) ? 20 :
          (j == 11) ? 26 : 61;
      v[j] = p[c];
      e[j] = ~p[g];
    end
  endfunction : pins_of

  function automatic int in_cell(input int k);
    if (k < 3) return k;
    if (k < 7) return k + 3;
    if (k < 9) return k + 9;
    if (k < 13) return k + 13;
    if (k < 16) return k + 15;
    if (k < 31) return 2 * k;
    if (k == 31) return 63;
    return k + 32;
  endfunction : in_cell

  initial begin
    #400000;
    err_total++;
    close_out();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    core_drive = '0;
    global_float_low = 1'b1;
    pin_in = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, mfg[i], 32'h0, rd);
      cmp("mfg reset", mfg_rst[i], rd);
      ahb(1'b1, mfg[i], 32'hFFFF_A5C0 + i, rd);
      ahb(1'b0, mfg[i], 32'h0, rd);
      cmp("mfg readback", 32'h0000_A5C0 + i, rd);
      cmp("mfg port", 16'hA5C0 + i, mfg_check_regs[16*i+:16]);
    end
    ahb(1'b1, 12'h080, 32'h1234_5678, rd);
    ahb(1'b0, 12'h080, 32'h0, rd);
    cmp("unmapped", 256'h0, rd);
    ahb(1'b0, `IDX_CTRL, 32'h0, rd);
    cmp("ctrl reset", `CTRL_RST, rd);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, mfg[i], 32'h0, rd);
      cmp("mfg after reset", mfg_rst[i], rd);
    end
    $display("test registers done");
    id_chk({32'hC0DE_F00D, 32'h2468_ACE1});
    $display("test identification done");
    core_drive <= {31'h2AAA_5555, 31'h0F0F_F0F0};
    for (int i = 0; i < 5; i++) begin
      load_ir(codes[i]);
      scan_master_i.scan(1'b0, 9, {247'h0, 9'h1B5}, so);
      cmp("bypass path", {247'h0, 8'hB5, 1'b0}, so[8:0]);
      if (codes[i] == `IR_HIGHZ) cmp("high-z oe", 256'h0, pin_oe);
      else if (codes[i] != `IR_CLAMP) cmp("bypass oe", 31'h0F0F_F0F0, pin_oe);
    end
    id_chk({32'h0F1E_2D3C, 32'h8796_A5B4});
    $display("test bypass done");
    pat = {64{4'hB}};
    pat[18] = 1'b0;
    pat[20] = 1'b1;
    pat[26] = 1'b0;
    pat[61] = 1'b0;
    pat[81] = 1'b1;
    load_ir(`IR_SAMPLE);
    scan_master_i.scan(1'b0, 196, pat, so);
    load_ir(`IR_EXTEST);
    pins_of(pat, ev, ee);
    cmp("extest out", ev, pin_out);
    cmp("extest oe", ee, pin_oe);
    load_ir(`IR_CLAMP);
    cmp("clamp out", ev, pin_out);
    cmp("clamp oe", ee, pin_oe);
    scan_master_i.scan(1'b0, 9, {247'h0, 9'h0C3}, so);
    cmp("clamp path", {247'h0, 8'hC3, 1'b0}, so[8:0]);
    repeat (4) @(posedge hclk);
    cmp("clamp hold out", ev, pin_out);
    cmp("clamp hold oe", ee, pin_oe);
    $display("test preload extest clamp done");
    pin_in <= 47'h5A5A_1234_C3F1;
    core_drive <= {31'h2AAA_5555, 31'h0F0F_F0F0};
    load_ir(`IR_SAMPLE);
    cmp("functional oe", 31'h0F0F_F0F0, pin_oe);
    scan_master_i.scan(1'b0, 204, {248'h0, 8'hA7}, so);
    for (int k = 0; k < `IN_N; k++) got_in[k] = so[in_cell(k)];
    cmp("input cells", 47'h5A5A_1234_C3F1, got_in);
    cmp("spare cells", pat[195:83], so[195:83]);
    cmp("boundary length", 8'hA7, so[203:196]);
    global_float_low <= 1'b0;
    repeat (6) @(posedge hclk);
    cmp("float oe", 256'h0, pin_oe);
    $display("test sample done");
    close_out();
  end
endmodule : boundary_scan_test_registers_test

`default_nettype wire
